/* File: logic/eeprom_pkg.sv */
// Constants and types shared by the serial EEPROM command core
package eeprom_pkg;
  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_WRITE   = 8'h02;
  localparam logic [7:0] OP_LSET    = 8'h06;
  localparam logic [7:0] OP_LCLR    = 8'h04;
  localparam logic [7:0] OP_SREAD   = 8'h05;
  localparam logic [7:0] OP_SWRITE  = 8'h01;
  localparam logic [7:0] OP_PERASE  = 8'h42;
  localparam logic [7:0] OP_SERASE  = 8'hD8;
  localparam logic [7:0] OP_CERASE  = 8'hC7;
  localparam logic [7:0] OP_SIG     = 8'hAB;
  localparam logic [7:0] OP_SLEEP   = 8'hB9;
  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int          ADDR_W     = 16;
  localparam int          MEM_BYTES  = 65536;
  localparam int          PAGE_BYTES = 128;
  localparam int          PAGE_W     = 7;
  localparam int          SECTOR_W   = 14;
  localparam logic [7:0]  ERASED     = 8'hFF;
  localparam logic [15:0] QUARTER_BASE = 16'hC000;
  localparam logic [15:0] HALF_BASE    = 16'h8000;
  // ----------------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------------
  localparam int         SR_PPE     = 7;
  localparam int         SR_PL_HI   = 3;
  localparam int         SR_PL_LO   = 2;
  localparam int         SR_WEL     = 1;
  localparam int         SR_BUSY    = 0;
  localparam logic       PPE_RESET  = 1'b0;
  localparam logic [1:0] PL_RESET   = 2'h0;
  // Arbitrary signature value, names no part
  localparam logic [7:0] SIGNATURE  = 8'h5A;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ   = 40000;
  localparam int WRITE_MS  = 5;
  localparam int ERASE_MS  = 10;
  localparam int WRITE_CYC = WRITE_MS * CLK_KHZ;
  localparam int ERASE_CYC = ERASE_MS * CLK_KHZ;
  localparam int TIMER_W   = 19;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FR_OP, FR_ADDR, FR_DATA, FR_END, FR_SKIP
  } frame_t;
  typedef enum logic [2:0] {
    JOB_NONE, JOB_PAGE, JOB_PERASE, JOB_SERASE, JOB_CERASE
  } job_t;
endpackage : eeprom_pkg

/* File: logic/spi_serial_eeprom_command_core.sv */
// Serial EEPROM command core: link-side decoder and system-side write engine
//
// Notes on behaviour
// R01 - Opcode shifts into 8-bit register on rising SCK
// R02 - Host holds select low, pause high throughout
// R03 - All bytes travel most significant bit first
// R04 - First bit sampled on first edge after select
// R05 - Pause freezes transfer, resumes where it stopped
// R06 - Decode array read and array write opcodes
// R07 - Latch set/clear opcodes; writes need the latch
// R08 - Decode page, sector and whole-array erase
// R09 - Decode signature release and deep sleep
// R10 - Read: opcode, address, bytes until select rises
// R11 - Read pointer increments, wraps FFFFh to 0000h
// R12 - Latch sets only on select rise after opcode
// R13 - Up to 128 bytes per page; erase built in
// R14 - Write address wraps inside its page
// R15 - Write starts only when select rises after D0
// R16 - No array data returned during internal write
// R17 - Latch cleared at reset and after operations
// R18 - Status: 8 bits, fixed field positions
// R19 - Busy flag follows internal write; not writable
// R20 - Latch flag settable by latch commands unless busy or in deep sleep
// R21 - Protect levels written by status write
// R22 - Status readable any time except in deep sleep, even when busy
// R23 - Protect levels guard none, quarter, half, all
// R24 - Pin plus enable bit block status writes
// R25 - Serial output driven only while sending
// R26 - Unknown opcode ignored until next select
`timescale 1ns/1ps
`default_nettype none
module spi_serial_eeprom_command_core #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYC,
  parameter int ERASE_CYCLES = eeprom_pkg::ERASE_CYC
) (
  input  wire logic clk_sys,
  input  wire logic ce,
  input  wire logic rstn,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic pause_n,
  input  wire logic protect_pin_n,
  output logic      so_o,
  output logic      so_oe,
  output logic      write_busy_o
);
  import eeprom_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_q1_r;
  logic rst_n_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_q1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n_r  <= rst_q1_r;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    frame_t      fr;
    logic [7:0]  op;
    logic [2:0]  bidx;
    logic [1:0]  nbytes;
    logic [15:0] addr;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic        tx_on;
    logic        wtog;
    logic [7:0]  wbyte;
    logic [6:0]  widx;
    logic [8:0]  st_s1;
    logic [8:0]  st_s2;
  } link_t;

  typedef struct packed {
    logic                cs_s1;
    logic                cs_s2;
    logic                cs_s3;
    logic                cs_s4;
    logic                tg_s1;
    logic                tg_s2;
    logic                tg_s3;
    logic                wp_s1;
    logic                wp_s2;
    logic                ppe;
    logic [1:0]          pl;
    logic                write_latch_flag;
    logic                busy;
    logic                deep_sleep_cmd;
    job_t                job;
    logic [15:0]         base;
    logic [16:0]         sweep;
    logic [16:0]         span;
    logic [TIMER_W-1:0]  timer;
    logic [PAGE_BYTES-1:0] mask;
  } sys_t;

  link_t s_r;
  link_t s_nxt;
  sys_t  y_r;
  sys_t  y_nxt;
  logic  fresh_r;
  logic  so_r;
  logic  oe_r;
  logic [7:0] mem   [MEM_BYTES];
  logic [7:0] pbuf  [PAGE_BYTES];
  logic [7:0] status_live;
  logic [7:0] byte_in;
  logic [15:0] addr_full;
  logic [2:0]  bidx0;
  frame_t      fr0;

  // Read-only bits track live state; writable bits are held copies
  assign status_live = {y_r.ppe, 3'h0, y_r.pl, y_r.write_latch_flag, y_r.busy}; // R18

  // ----------------------------------------------------------------------
  // Link side, clocked by SCK
  // ----------------------------------------------------------------------
  // Frame start is marked asynchronously by select high, since SCK is idle
  // then; the frame summary itself survives for the system side to judge.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      fresh_r <= 1'b1;
    end else if (pause_n) begin
      fresh_r <= 1'b0; // R04
    end
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.st_s1  = {y_r.deep_sleep_cmd, status_live};
    s_nxt.st_s2  = s_r.st_s1;
    fr0          = fresh_r ? FR_OP : s_r.fr;
    bidx0        = fresh_r ? 3'h0 : s_r.bidx;
    byte_in      = {s_r.sh[6:0], si}; // R03
    addr_full    = {s_r.addr[14:0], si};
    if (pause_n) begin // R05
      s_nxt.fr   = fr0;
      s_nxt.sh   = byte_in; // R01
      s_nxt.bidx = bidx0 + 3'h1;
      if (fresh_r) begin
        s_nxt.tx_on  = 1'b0;
        s_nxt.nbytes = 2'h0;
      end
      case (fr0)
        FR_OP: begin
          if (bidx0 == 3'h7) begin
            s_nxt.op = byte_in; // R01
            s_nxt.fr = FR_SKIP; // R26
            if (s_r.st_s2[8] && byte_in != OP_SIG) begin
              s_nxt.fr = FR_SKIP; // R09
            end else begin
              case (byte_in)
                OP_READ: begin // R06
                  s_nxt.fr = s_r.st_s2[SR_BUSY] ? FR_SKIP : FR_ADDR; // R16
                end
                OP_WRITE, OP_PERASE, OP_SERASE, OP_SIG: begin // R08
                  s_nxt.fr = FR_ADDR;
                end
                OP_SREAD: begin
                  s_nxt.fr    = FR_DATA; // R22
                  s_nxt.tx    = s_r.st_s2[7:0];
                  s_nxt.tx_on = 1'b1;
                end
                OP_SWRITE: begin
                  s_nxt.fr = FR_DATA; // R21
                end
                OP_LSET, OP_LCLR, OP_CERASE, OP_SLEEP: begin // R07
                  s_nxt.fr = FR_END;
                end
                default: begin
                  s_nxt.fr = FR_SKIP; // R26
                end
              endcase
            end
          end
        end
        FR_ADDR: begin
          s_nxt.addr = addr_full;
          if (bidx0 == 3'h7) begin
            s_nxt.nbytes = s_r.nbytes + 2'h1;
            if (s_r.nbytes == 2'h1) begin
              s_nxt.nbytes = 2'h0;
              s_nxt.fr     = FR_DATA;
              if (s_r.op == OP_READ) begin
                s_nxt.tx    = mem[addr_full]; // R10
                s_nxt.tx_on = 1'b1;
              end else if (s_r.op == OP_SIG) begin
                s_nxt.tx    = SIGNATURE; // R09
                s_nxt.tx_on = 1'b1;
              end else if (s_r.op != OP_WRITE) begin
                s_nxt.fr = FR_END;
              end
            end
          end
        end
        FR_DATA: begin
          if (bidx0 == 3'h7) begin
            s_nxt.wbyte = byte_in;
            if (s_r.nbytes != 2'h3) begin
              s_nxt.nbytes = s_r.nbytes + 2'h1;
            end
            case (s_r.op)
              OP_READ: begin
                s_nxt.addr = s_r.addr + 16'h0001; // R11
                s_nxt.tx   = mem[s_r.addr + 16'h0001];
              end
              OP_SREAD: s_nxt.tx = s_r.st_s2[7:0]; // R22
              OP_SIG:   s_nxt.tx = SIGNATURE;
              OP_WRITE: begin
                s_nxt.widx = s_r.addr[PAGE_W-1:0];
                s_nxt.wtog = ~s_r.wtog;
                s_nxt.addr = {s_r.addr[15:PAGE_W],
                              s_r.addr[PAGE_W-1:0] + 7'h01}; // R14
              end
              default: s_nxt.tx = s_r.tx;
            endcase
          end
        end
        FR_END: begin
          s_nxt.fr = FR_SKIP; // R12
        end
        FR_SKIP: begin
          s_nxt.tx_on = 1'b0; // R26
        end
        default: s_nxt.fr = FR_SKIP;
      endcase
    end
  end

  always_ff @(posedge sck or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r    <= '0;
      s_r.fr <= FR_SKIP;
    end else begin
      s_r    <= s_nxt;
    end
  end

  // Output bits change on the falling edge so the host samples mid-bit
  always_ff @(negedge sck or negedge rst_n_r) begin
    if (!rst_n_r) begin
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (pause_n) begin
      so_r <= s_r.tx[~s_r.bidx]; // R03
      oe_r <= s_r.tx_on;
    end
  end

  assign so_o  = so_r;
  assign so_oe = oe_r & ~cs_n & pause_n & ~fresh_r; // R25

  // ----------------------------------------------------------------------
  // System side: commit, page buffer, internal write cycle
  // ----------------------------------------------------------------------
  function automatic logic guarded(input logic [1:0] pl,
                                   input logic [15:0] a);
    case (pl)
      2'h0:    guarded = 1'b0; // R23
      2'h1:    guarded = (a >= QUARTER_BASE);
      2'h2:    guarded = (a >= HALF_BASE);
      default: guarded = 1'b1;
    endcase
  endfunction : guarded

  logic commit;
  logic start;
  logic byte_ev;
  logic ok8;
  logic ok24;
  logic okw;
  logic oks;

  always_comb begin
    y_nxt       = y_r;
    y_nxt.cs_s1 = cs_n;
    y_nxt.cs_s2 = y_r.cs_s1;
    y_nxt.cs_s3 = y_r.cs_s2;
    y_nxt.cs_s4 = y_r.cs_s3;
    y_nxt.tg_s1 = s_r.wtog;
    y_nxt.tg_s2 = y_r.tg_s1;
    y_nxt.tg_s3 = y_r.tg_s2;
    y_nxt.wp_s1 = protect_pin_n;
    y_nxt.wp_s2 = y_r.wp_s1;
    // One extra stage lets the last byte toggle land before the commit
    commit  = y_r.cs_s3 & ~y_r.cs_s4 & ~y_r.busy;
    start   = ~y_r.cs_s3 & y_r.cs_s4 & ~y_r.busy;
    byte_ev = (y_r.tg_s2 ^ y_r.tg_s3) & ~y_r.busy;
    ok8  = (s_r.fr == FR_END) && (s_r.bidx == 3'h0); // R12
    ok24 = ok8;
    okw  = (s_r.fr == FR_DATA) && (s_r.bidx == 3'h0)
           && (s_r.nbytes != 2'h0); // R15
    oks  = okw && (s_r.nbytes == 2'h1);
    if (start) begin
      y_nxt.mask = '0;
    end
    if (byte_ev) begin
      y_nxt.mask[s_r.widx] = 1'b1; // R13
    end
    if (commit) begin
      if (y_r.deep_sleep_cmd) begin
        if (s_r.op == OP_SIG && s_r.fr != FR_OP) begin
          y_nxt.deep_sleep_cmd = 1'b0; // R09
        end
      end else begin
        case (s_r.op)
          OP_LSET:   if (ok8) y_nxt.write_latch_flag = 1'b1; // R20
          OP_LCLR:   if (ok8) y_nxt.write_latch_flag = 1'b0; // R17
          OP_SLEEP:  if (ok8) y_nxt.deep_sleep_cmd = 1'b1; // R09
          OP_SWRITE: begin
            if (oks && y_r.write_latch_flag && !(y_r.ppe && !y_r.wp_s2)) begin // R24
              y_nxt.ppe = s_r.wbyte[SR_PPE];
              y_nxt.pl  = s_r.wbyte[SR_PL_HI:SR_PL_LO]; // R21
              y_nxt.write_latch_flag = 1'b0; // R17
            end
          end
          OP_WRITE: begin
            if (okw && y_r.write_latch_flag && !guarded(y_r.pl, s_r.addr)) begin // R07
              y_nxt.job  = JOB_PAGE;
              y_nxt.span = 17'(PAGE_BYTES);
            end
          end
          OP_PERASE: begin
            if (ok24 && y_r.write_latch_flag && !guarded(y_r.pl, s_r.addr)) begin // R08
              y_nxt.job  = JOB_PERASE;
              y_nxt.span = 17'(PAGE_BYTES);
            end
          end
          OP_SERASE: begin
            if (ok24 && y_r.write_latch_flag && !guarded(y_r.pl, s_r.addr)) begin
              y_nxt.job  = JOB_SERASE;
              y_nxt.span = 17'(1 << SECTOR_W);
            end
          end
          OP_CERASE: begin
            if (ok8 && y_r.write_latch_flag && y_r.pl == 2'h0) begin // R23
              y_nxt.job  = JOB_CERASE;
              y_nxt.span = 17'(MEM_BYTES);
            end
          end
          default: y_nxt.write_latch_flag = y_r.write_latch_flag; // R26
        endcase
        if (y_nxt.job != JOB_NONE) begin
          y_nxt.busy  = 1'b1; // R19
          y_nxt.sweep = '0;
          y_nxt.base  = s_r.addr;
          y_nxt.timer = (s_r.op == OP_WRITE || s_r.op == OP_PERASE)
                        ? TIMER_W'(WRITE_CYCLES) : TIMER_W'(ERASE_CYCLES);
        end
      end
    end
    if (y_r.busy) begin
      if (y_r.timer != '0) begin
        y_nxt.timer = y_r.timer - 1'b1;
      end
      if (y_r.sweep != y_r.span) begin
        y_nxt.sweep = y_r.sweep + 17'h00001;
      end else if (y_r.timer == '0) begin
        y_nxt.busy = 1'b0; // R19
        y_nxt.job  = JOB_NONE;
        y_nxt.write_latch_flag  = 1'b0; // R17
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      y_r     <= '0;
      y_r.ppe <= PPE_RESET;
      y_r.pl  <= PL_RESET;
      y_r.job <= JOB_NONE;
    end else if (ce) begin
      y_r <= y_nxt;
    end
  end

  // One array byte per cycle; the busy time covers the whole sweep
  logic [15:0] sweep_addr;

  always_comb begin
    case (y_r.job)
      JOB_PAGE, JOB_PERASE:
        sweep_addr = {y_r.base[15:PAGE_W], y_r.sweep[PAGE_W-1:0]}; // R14
      JOB_SERASE:
        sweep_addr = {y_r.base[15:SECTOR_W], y_r.sweep[SECTOR_W-1:0]};
      default: sweep_addr = y_r.sweep[15:0];
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (ce && byte_ev) begin
      pbuf[s_r.widx] <= s_r.wbyte;
    end
    if (ce && y_r.busy && y_r.sweep != y_r.span) begin
      if (y_r.job == JOB_PAGE) begin
        if (y_r.mask[y_r.sweep[PAGE_W-1:0]]) begin
          mem[sweep_addr] <= pbuf[y_r.sweep[PAGE_W-1:0]]; // R13
        end
      end else begin
        mem[sweep_addr] <= ERASED; // R08
      end
    end
  end

  assign write_busy_o = y_r.busy;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_busy_holds;
    @(posedge clk_sys) disable iff (!rst_n_r)
      $rose(y_r.busy) |-> y_r.busy [*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds) // R19
    else $error("busy dropped too early");

  property p_wel_after_job;
    @(posedge clk_sys) disable iff (!rst_n_r)
      $fell(y_r.busy) |-> !y_r.write_latch_flag;
  endproperty
  a_wel_after_job: assert property (p_wel_after_job) // R17
    else $error("latch not cleared after write cycle");

  property p_job_needs_wel;
    @(posedge clk_sys) disable iff (!rst_n_r)
      $rose(y_r.busy) |-> $past(y_r.write_latch_flag);
  endproperty
  a_job_needs_wel: assert property (p_job_needs_wel) // R07
    else $error("write cycle without latch");

  property p_cerase_guard;
    @(posedge clk_sys) disable iff (!rst_n_r)
      ($rose(y_r.busy) && y_r.job == JOB_CERASE) |-> y_r.pl == 2'h0;
  endproperty
  a_cerase_guard: assert property (p_cerase_guard) // R23
    else $error("chip erase with protection set");

  property p_status_lock;
    @(posedge clk_sys) disable iff (!rst_n_r)
      $changed(y_r.pl) |-> $past(!y_r.ppe || y_r.wp_s2);
  endproperty
  a_status_lock: assert property (p_status_lock) // R24
    else $error("status written while pin locked");

  property p_page_wrap;
    @(posedge sck) disable iff (!rst_n_r || cs_n)
      (!fresh_r && pause_n && s_r.fr == FR_DATA && s_r.op == OP_WRITE
       && s_r.bidx == 3'h7) |=> s_r.addr[15:7] == $past(s_r.addr[15:7]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) // R14
    else $error("write address left its page");

  property p_read_step;
    @(posedge sck) disable iff (!rst_n_r || cs_n)
      (!fresh_r && pause_n && s_r.fr == FR_DATA && s_r.op == OP_READ
       && s_r.bidx == 3'h7) |=> s_r.addr == $past(s_r.addr) + 16'h0001;
  endproperty
  a_read_step: assert property (p_read_step) // R11
    else $error("read pointer did not advance");

  property p_pause_freeze;
    @(posedge sck) disable iff (!rst_n_r || cs_n)
      (!pause_n && !fresh_r) |=> s_r.bidx == $past(s_r.bidx)
                                && s_r.fr == $past(s_r.fr);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) // R05
    else $error("frame moved during pause");
endmodule : spi_serial_eeprom_command_core
`default_nettype wire

/* File: testbench/spi_host_model.sv */
// Behavioural SPI host driving the EEPROM link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      pause_n,
  input  wire logic so_o,
  input  wire logic so_oe
);
  // ----------------------------------------------------------------------
  // Frame tasks; the 64 ns link clock only runs inside frames
  // ----------------------------------------------------------------------
  initial begin
    sck     = 1'b0;
    cs_n    = 1'b1;
    si      = 1'b0;
    pause_n = 1'b1;
  end
  task automatic open_frame();
    cs_n = 1'b0;
    #40;
  endtask : open_frame
  // Long gap so the system side can judge the finished frame
  task automatic close_frame();
    #20;
    cs_n = 1'b1;
    si   = ~si;
    #300;
  endtask : close_frame
  task automatic xfer(input logic [7:0] tx, input int nb, input bit hold,
                      output logic [7:0] rx, output logic oe,
                      output logic hz);
    rx = 8'h00;
    oe = 1'b0;
    hz = 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      si = tx[i];
      #32;
      rx[i] = so_o;
      oe    = oe | so_oe;
      sck   = 1'b1;
      #32;
      sck = 1'b0;
      if (hold && i == 4) begin
        #8;
        pause_n = 1'b0;
        #30;
        // Shared clock keeps running while paused; the frame must not move
        sck = 1'b1;
        #32;
        sck = 1'b0;
        #38;
        hz      = so_oe;
        pause_n = 1'b1;
        #8;
      end
    end
    si = ~si;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the serial EEPROM command core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eeprom_pkg::*;
  logic       clk_sys, rstn, ce, protect_pin_n, latch, ppe;
  logic       sck, cs_n, si, pause_n, so_o, so_oe, write_busy_o;
  logic       oe, hz;
  logic [1:0] lvl;
  logic [7:0] rx;
  logic [7:0] mem [int];
  logic [7:0] ops [3];
  int         num_errors, tests_run;
  spi_serial_eeprom_command_core #(
    .WRITE_CYCLES(300),
    .ERASE_CYCLES(600)
  ) uut (
    .clk_sys(clk_sys), .ce(ce), .rstn(rstn), .sck(sck), .cs_n(cs_n),
    .si(si), .pause_n(pause_n), .protect_pin_n(protect_pin_n),
    .so_o(so_o), .so_oe(so_oe), .write_busy_o(write_busy_o)
  );
  spi_host_model host (
    .sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n),
    .so_o(so_o), .so_oe(so_oe)
  );
  // ----------------------------------------------------------------------
  // Checking and link helpers
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  function automatic logic [7:0] sr(input logic b);
    return {ppe, 3'b000, lvl, latch, b};
  endfunction : sr
  function automatic bit prot(input logic [15:0] a);
    return lvl == 2'h3 || (lvl == 2'h2 && a >= HALF_BASE) ||
           (lvl == 2'h1 && a >= QUARTER_BASE);
  endfunction : prot
  task automatic bx(input logic [7:0] tx);
    host.xfer(tx, 8, 1'b0, rx, oe, hz);
  endtask : bx
  task automatic ad(input logic [15:0] a);
    bx(a[15:8]);
    bx(a[7:0]);
  endtask : ad
  task automatic cmd(input logic [7:0] op);
    host.open_frame();
    bx(op);
    host.close_frame();
    if (op == OP_LSET) latch = 1'b1;
    if (op == OP_LCLR) latch = 1'b0;
  endtask : cmd
  task automatic sr_chk(input logic [7:0] exp);
    host.open_frame();
    bx(OP_SREAD);
    bx(8'h00);
    chk8(rx, exp);
    host.close_frame();
  endtask : sr_chk
  // Opcode, address and one byte; oe reflects the last byte only
  task automatic probe(input logic [7:0] op, input logic exp);
    host.open_frame();
    bx(op);
    ad(16'h0000);
    bx(8'h00);
    chk1(oe, exp);
    host.close_frame();
  endtask : probe
  // Bounded wait for the internal cycle to end
  task automatic idle(input bit clr);
    for (int i = 0; i < 3000 && write_busy_o !== 1'b0; i++) begin
      @(negedge clk_sys);
    end
    if (write_busy_o !== 1'b0) begin
      num_errors++;
      report_and_stop();
    end
    if (clr) latch = 1'b0;
  endtask : idle
  task automatic wr(input logic [15:0] a, input int n);
    logic [7:0] d;
    bit         ok;
    ok = latch && !prot(a);
    host.open_frame();
    bx(OP_WRITE);
    ad(a);
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      bx(d);
      if (ok) mem[{a[15:7], 7'(a[6:0] + k)}] = d;
    end
    host.close_frame();
    chk1(write_busy_o, ok);
  endtask : wr
  task automatic rd(input logic [15:0] a, input int n);
    host.open_frame();
    bx(OP_READ);
    ad(a);
    for (int k = 0; k < n; k++) begin
      host.xfer(8'h00, 8, k == 0, rx, oe, hz);
      chk8(rx, mem[16'(a + k)]);
      if (k == 0) chk1(hz, 1'b0);
    end
    host.close_frame();
  endtask : rd
  task automatic er(input logic [7:0] op, input logic [15:0] a);
    bit ok;
    ok = latch && !prot(a) && (op != OP_CERASE || lvl == 2'h0);
    host.open_frame();
    bx(op);
    if (op != OP_CERASE) ad(a);
    host.close_frame();
    chk1(write_busy_o, ok);
    if (ok) begin
      for (int k = 0; k < 128; k++) mem[{a[15:7], 7'(k)}] = ERASED;
      idle(1'b1);
    end
  endtask : er
  task automatic sw(input logic [7:0] v);
    bit ok;
    ok = latch && (ppe == 1'b0 || protect_pin_n);
    host.open_frame();
    bx(OP_SWRITE);
    bx(v);
    host.close_frame();
    if (ok) begin
      ppe = v[7];
      lvl = v[3:2];
      idle(1'b1);
    end
  endtask : sw
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    #2_000_000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    protect_pin_n = 1'b1;
    {latch, ppe, lvl, num_errors, tests_run} = '0;
    ops = '{OP_PERASE, OP_SERASE, OP_CERASE};
    void'($urandom(32'hCCCC6FBF));
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    sr_chk(sr(1'b0));
    cmd(OP_LSET);
    sr_chk(sr(1'b0));
    cmd(OP_LCLR);
    sr_chk(sr(1'b0));
    wr(16'h1280, 1);
    cmd(OP_LSET);
    wr(16'h12FE, 4);
    probe(OP_READ, 1'b0);
    sr_chk(sr(1'b1));
    idle(1'b1);
    sr_chk(sr(1'b0));
    rd(16'h1280, 2);
    rd(16'h12FE, 2);
    cmd(OP_LSET);
    wr(16'hFFFF, 1);
    idle(1'b1);
    cmd(OP_LSET);
    wr(16'h0000, 1);
    idle(1'b1);
    rd(16'hFFFF, 2);
    cmd(OP_LSET);
    host.open_frame();
    bx(OP_WRITE);
    ad(16'h1280);
    bx(8'h55);
    host.xfer(8'hA5, 3, 1'b0, rx, oe, hz);
    host.close_frame();
    chk1(write_busy_o, 1'b0);
    cmd(OP_LCLR);
    rd(16'h1280, 1);
    cmd(OP_LSET);
    sw(8'h8C);
    sr_chk(sr(1'b0));
    foreach (ops[i]) begin
      cmd(OP_LSET);
      er(ops[i], 16'h0000);
    end
    wr(16'h0000, 1);
    cmd(OP_LCLR);
    @(negedge clk_sys);
    protect_pin_n = 1'b0;
    cmd(OP_LSET);
    sw(8'h00);
    cmd(OP_LCLR);
    sr_chk(sr(1'b0));
    @(negedge clk_sys);
    protect_pin_n = 1'b1;
    cmd(OP_LSET);
    sw(8'h00);
    sr_chk(sr(1'b0));
    cmd(OP_LSET);
    er(OP_PERASE, 16'h12FE);
    rd(16'h12FE, 2);
    probe(8'hFF, 1'b0);
    cmd(OP_SLEEP);
    probe(OP_SREAD, 1'b0);
    host.open_frame();
    bx(OP_SIG);
    ad(16'h0000);
    bx(8'h00);
    chk8(rx, SIGNATURE);
    host.close_frame();
    probe(OP_SREAD, 1'b1);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
